// ==== hdl/psl_pkg.sv ====
// Package with constants and carrier types for the status lamp controller
package psl_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned BLINK_HZ         = 1;
  // Half period of the blink, in clock cycles
  localparam int unsigned BLINK_HALF_CYC   = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned FAN_MIN_RPM      = 750;
  localparam int unsigned RPM_W            = 16;
  // Longest time for green to turn yellow after DC removal, in ms
  localparam int unsigned DC_LOSS_MAX_MS   = 3000;
  localparam int unsigned DC_LOSS_MAX_CYC  = (CLK_HZ / 1000) * DC_LOSS_MAX_MS;

  typedef struct packed {
    logic ac_valid;
    logic dc_in_valid;
    logic dc_out_valid;
    logic backup_active;
  } psl_power_type;

  typedef struct packed {
    logic supply_failure;
    logic protect_latched;
    logic protect_temp_off;
    logic short_overload;
    logic short_latched_off;
  } psl_fault_type;

  typedef enum logic [3:0] {
    PG_OFF    = 4'b0001,
    PG_YELLOW = 4'b0010,
    PG_GREEN  = 4'b0100,
    PG_BLINK  = 4'b1000
  } psl_pg_state_type;

endpackage : psl_pkg

// ==== hdl/psl_blink_gen.sv ====
// Shared 1 Hz, 50 % duty blink timebase
`timescale 1ns/1ps
module psl_blink_gen
  import psl_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  output logic      o_blink
);

  logic [31:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 32'h0000_0000;
      o_blink <= 1'b0;
    end else if (cnt_reg >= HALF_CYC - 1) begin
      cnt_reg <= 32'h0000_0000;
      o_blink <= ~o_blink;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

endmodule : psl_blink_gen

// ==== hdl/psl_fan_monitor.sv ====
// Fan tachometer threshold check
`timescale 1ns/1ps
module psl_fan_monitor
  import psl_pkg::*;
#(
  parameter int unsigned MIN_RPM = FAN_MIN_RPM
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [RPM_W-1:0] i_rpm,
  output logic                  o_fan_fail
);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fan_fail <= 1'b0;
    end else begin
      o_fan_fail <= (i_rpm < RPM_W'(MIN_RPM));
    end
  end

endmodule : psl_fan_monitor

// ==== hdl/psl_status_led.sv ====
// Front-panel power-good and fault lamp controller
//
// Operation
// - Both lamps dark without valid AC, except during a backup phase.
// - Power-good steady yellow: output valid, DC input not valid.
// - Power-good steady green: output valid and DC input valid, outside a backup phase.
// - Green turns yellow within three seconds after DC removal.
// - Power-good blinks yellow at 1 Hz during backup on valid DC.
// - Power-good off whenever the DC output is invalid.
// - Fault lamp steady for failures and latching or temporary protections.
// - Short or overload keeps fault dark until latched off, AC only.
// - In DC backup, short or overload latch-off leaves fault lamp off.
// - Fan below 750 RPM is failure; fault lamp blinks at 1 Hz.
// - Fan failure alone never requests a supply shutdown.
// - Fault lamp off when no fault, protection or fan failure exists.
`timescale 1ns/1ps
module psl_status_led
  import psl_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC,
  parameter int unsigned MIN_RPM  = FAN_MIN_RPM
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_RST_B,
  input  wire logic             I_AC_VALID,
  input  wire logic             I_DC_IN_VALID,
  input  wire logic             I_DC_OUT_VALID,
  input  wire logic             I_BACKUP_ACTIVE,
  input  wire logic             I_SUPPLY_FAILURE,
  input  wire logic             I_PROTECT_LATCHED,
  input  wire logic             I_PROTECT_TEMP_OFF,
  input  wire logic             I_SHORT_OVERLOAD,
  input  wire logic             I_SHORT_LATCHED_OFF,
  input  wire logic [RPM_W-1:0] I_FAN_RPM,
  output logic                  O_PG_GREEN,
  output logic                  O_PG_YELLOW,
  output logic                  O_FAULT_RED,
  output logic                  O_FAN_FAIL,
  output logic                  O_SHUTDOWN_REQ
);

  psl_power_type    pwr;
  psl_fault_type    flt;
  psl_pg_state_type pg_state_reg;
  psl_pg_state_type pg_state_next;
  logic             blink;
  logic             fan_fail;
  logic             lamps_enabled;
  logic             fault_steady;
  logic             fault_red_next;

  assign pwr = '{ac_valid: I_AC_VALID, dc_in_valid: I_DC_IN_VALID,
                 dc_out_valid: I_DC_OUT_VALID, backup_active: I_BACKUP_ACTIVE};
  assign flt = '{supply_failure: I_SUPPLY_FAILURE, protect_latched: I_PROTECT_LATCHED,
                 protect_temp_off: I_PROTECT_TEMP_OFF, short_overload: I_SHORT_OVERLOAD,
                 short_latched_off: I_SHORT_LATCHED_OFF};

  psl_blink_gen #(
    .HALF_CYC (HALF_CYC)
  ) psl_blink_gen_inst (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .o_blink (blink)
  );

  psl_fan_monitor #(
    .MIN_RPM (MIN_RPM)
  ) psl_fan_monitor_inst (
    .i_clk      (I_CLOCK),
    .i_rst_b    (I_RST_B),
    .i_rpm      (I_FAN_RPM),
    .o_fan_fail (fan_fail)
  );

  assign lamps_enabled = pwr.ac_valid | pwr.backup_active;

  // Decision is made every cycle, so DC removal shows at the next edge, far inside 3 s
  always_comb begin
    pg_state_next = PG_OFF;
    if (!lamps_enabled) begin
      pg_state_next = PG_OFF;
    end else if (!pwr.dc_out_valid) begin
      pg_state_next = PG_OFF;
    end else if (pwr.backup_active && pwr.dc_in_valid) begin
      pg_state_next = PG_BLINK;
    end else if (pwr.dc_in_valid) begin
      pg_state_next = PG_GREEN;
    end else begin
      pg_state_next = PG_YELLOW;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pg_state_reg <= PG_OFF;
    end else begin
      pg_state_reg <= pg_state_next;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PG_GREEN  <= 1'b0;
      O_PG_YELLOW <= 1'b0;
    end else begin
      case (pg_state_next)
        PG_GREEN: begin
          O_PG_GREEN  <= 1'b1;
          O_PG_YELLOW <= 1'b0;
        end
        PG_YELLOW: begin
          O_PG_GREEN  <= 1'b0;
          O_PG_YELLOW <= 1'b1;
        end
        PG_BLINK: begin
          O_PG_GREEN  <= 1'b0;
          O_PG_YELLOW <= blink;
        end
        default: begin
          O_PG_GREEN  <= 1'b0;
          O_PG_YELLOW <= 1'b0;
        end
      endcase
    end
  end

  assign fault_steady = flt.supply_failure | flt.protect_latched | flt.protect_temp_off |
                        (flt.short_latched_off & ~pwr.backup_active & pwr.ac_valid);

  always_comb begin
    fault_red_next = 1'b0;
    if (!lamps_enabled) begin
      fault_red_next = 1'b0;
    end else if (fault_steady) begin
      fault_red_next = 1'b1;
    end else if (fan_fail) begin
      fault_red_next = blink;
    end else begin
      fault_red_next = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FAULT_RED    <= 1'b0;
      O_FAN_FAIL     <= 1'b0;
      O_SHUTDOWN_REQ <= 1'b0;
    end else begin
      O_FAULT_RED    <= fault_red_next;
      O_FAN_FAIL     <= fan_fail;
      O_SHUTDOWN_REQ <= flt.protect_temp_off;
    end
  end

endmodule : psl_status_led

// ==== test/psl_status_led_properties.sv ====
// Port-level checks of the status lamp controller
`timescale 1ns/1ps
module psl_status_led_properties
  import psl_pkg::*;
#(parameter int unsigned MIN_RPM = FAN_MIN_RPM) (
  input wire logic I_CLOCK, I_RST_B, I_AC_VALID, I_DC_IN_VALID, I_DC_OUT_VALID,
  input wire logic I_BACKUP_ACTIVE, I_SUPPLY_FAILURE, I_PROTECT_LATCHED,
  input wire logic I_PROTECT_TEMP_OFF, I_SHORT_LATCHED_OFF, O_PG_GREEN, O_PG_YELLOW,
  input wire logic O_FAULT_RED, O_FAN_FAIL, O_SHUTDOWN_REQ,
  input wire logic [RPM_W-1:0] I_FAN_RPM
);
  logic on, hard, fan_ok, bk;
  assign on     = I_AC_VALID | I_BACKUP_ACTIVE;
  assign hard   = I_SUPPLY_FAILURE | I_PROTECT_LATCHED | I_PROTECT_TEMP_OFF;
  assign fan_ok = I_FAN_RPM >= RPM_W'(MIN_RPM);
  assign bk     = I_BACKUP_ACTIVE & I_DC_IN_VALID & I_DC_OUT_VALID;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  property p_dark; !on |=> !(O_PG_GREEN | O_PG_YELLOW | O_FAULT_RED); endproperty
  a_dark: assert property (p_dark) else $error("lamp lit without AC");
  property p_off; !I_DC_OUT_VALID |=> !(O_PG_GREEN | O_PG_YELLOW); endproperty
  a_off: assert property (p_off) else $error("power lamp lit");
  property p_grn; I_AC_VALID & !I_BACKUP_ACTIVE & I_DC_OUT_VALID & I_DC_IN_VALID
    |=> O_PG_GREEN & !O_PG_YELLOW; endproperty
  a_grn: assert property (p_grn) else $error("green missing");
  property p_yel; I_AC_VALID & I_DC_OUT_VALID & !I_DC_IN_VALID
    |=> O_PG_YELLOW & !O_PG_GREEN; endproperty
  a_yel: assert property (p_yel) else $error("yellow missing");
  property p_red; on & hard |=> O_FAULT_RED; endproperty
  a_red: assert property (p_red) else $error("red missing");
  property p_slat; I_AC_VALID & !I_BACKUP_ACTIVE & I_SHORT_LATCHED_OFF |=> O_FAULT_RED;
  endproperty
  a_slat: assert property (p_slat) else $error("latch-off red missing");
  property p_nored; fan_ok[*3] ##0 (!hard & !(I_SHORT_LATCHED_OFF & I_AC_VALID
    & !I_BACKUP_ACTIVE)) |=> !O_FAULT_RED; endproperty
  a_nored: assert property (p_nored) else $error("red lit");
  property p_fan; (fan_ok[*3] |=> !O_FAN_FAIL) and ((!fan_ok)[*3] |=> O_FAN_FAIL);
  endproperty
  a_fan: assert property (p_fan) else $error("fan flag wrong");
  property p_shut; $past(I_RST_B) |-> O_SHUTDOWN_REQ == $past(I_PROTECT_TEMP_OFF);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown wrong");
  property p_blink; bk[*3] ##0 $rose(O_PG_YELLOW) |-> (O_PG_YELLOW | !$past(bk))[*8];
  endproperty
  a_blink: assert property (p_blink) else $error("blink too short");
endmodule : psl_status_led_properties

// ==== test/psl_lamp_model.sv ====
// Behavioural front-panel lamps
`timescale 1ns/1ps
module psl_lamp_model (
  input  wire logic  i_green,
  input  wire logic  i_yellow,
  input  wire logic  i_red,
  output logic [2:0] o_lamps
);
  // A bi-colour lamp driven both ways shows neither colour
  assign o_lamps = {i_green & ~i_yellow, i_yellow & ~i_green, i_red};
endmodule : psl_lamp_model

// ==== test/test_psl_status_led.sv ====
// Self-checking bench for the status lamp controller
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_psl_status_led
  import psl_pkg::*;
;
  logic             clk = 0, rst_b = 0, chk = 0, g, y, r, ff, sd;
  psl_power_type    pw  = '0;
  psl_fault_type    ft  = '0;
  logic [RPM_W-1:0] rpm = 16'h0400;
  logic [3:0]       q[$], e;
  logic [2:0]       lamps;
  int               err_count = 0, comparisons = 0, cyc = 0, seed = 32'h8752;
  psl_status_led #(.HALF_CYC(10)) psl_status_led_inst (.I_CLOCK(clk), .I_RST_B(rst_b),
    .I_AC_VALID(pw.ac_valid), .I_DC_IN_VALID(pw.dc_in_valid),
    .I_DC_OUT_VALID(pw.dc_out_valid), .I_BACKUP_ACTIVE(pw.backup_active),
    .I_SUPPLY_FAILURE(ft.supply_failure), .I_PROTECT_LATCHED(ft.protect_latched),
    .I_PROTECT_TEMP_OFF(ft.protect_temp_off), .I_SHORT_OVERLOAD(ft.short_overload),
    .I_SHORT_LATCHED_OFF(ft.short_latched_off), .I_FAN_RPM(rpm), .O_PG_GREEN(g),
    .O_PG_YELLOW(y), .O_FAULT_RED(r), .O_FAN_FAIL(ff), .O_SHUTDOWN_REQ(sd));
  psl_lamp_model psl_lamp_model_inst (.i_green(g), .i_yellow(y), .i_red(r), .o_lamps(lamps));
  initial forever #5 clk = ~clk;
  task close_out();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  // Blinking cases: lamps in one phase, fan flag up
  always @(posedge clk) if (chk) begin
    e = q.pop_front();
    if (e[3]) `CHK({g, y ^ r, ff}, 3'h1)
    else `CHK(lamps, e[2:0])
    `CHK(sd, ft.protect_temp_off)
    `CHK(ff, (rpm < RPM_W'(FAN_MIN_RPM)))
  end
  function automatic logic [15:0] rok();
    return 16'(FAN_MIN_RPM + {$random(seed)} % 3000);
  endfunction : rok
  // Holds inputs long enough for a full blink phase before the check
  task apply(input logic [3:0] p, input logic [4:0] f, input logic [15:0] rp,
             input logic [3:0] ex);
    @(posedge clk);
    pw <= p; ft <= f; rpm <= rp;
    repeat (24) @(posedge clk);
    q.push_back(ex); chk <= 1;
    @(posedge clk);
    chk <= 0;
  endtask : apply
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    apply(4'hE, 5'h00, rok(), 4'h4);
    apply(4'hA, 5'h00, rok(), 4'h2);
    apply(4'h6, 5'h10, rok(), 4'h0);
    apply(4'hC, 5'h02, rok(), 4'h0);
    apply(4'hC, 5'h01, rok(), 4'h1);
    apply(4'h5, 5'h01, rok(), 4'h0);
    for (int i = 0; i < 3; i++) apply(4'hE, 5'h10 >> i, rok(), 4'h5);
    apply(4'h7, 5'h00, 16'h02ED, 4'h8);
    apply(4'hE, 5'h08, 16'h02ED, 4'h5);
    apply(4'hE, 5'h04, 16'h0000, 4'h5);
    apply(4'hE, 5'h00, 16'h02EE, 4'h4);
    close_out();
  end
endmodule : test_psl_status_led
bind psl_status_led psl_status_led_properties #(.MIN_RPM(MIN_RPM)) psl_status_led_properties_inst (.*);
